// file: rtl/rmgc_defines.vh
// register map, field layout and reset values of the relay mux gain control
`ifndef RMGC_DEFINES_VH
`define RMGC_DEFINES_VH

`define RMGC_NUM_CH 16
`define RMGC_ADDR_W 8
`define RMGC_DATA_W 16
// data registers: page 1 word 1, indices 0x00..0x0f
`define RMGC_DATA_BASE 8'h00
// gain registers: page 13, indices 0xc0..0xcf
`define RMGC_GAIN_BASE 8'hc0
`define RMGC_CFG_ADDR 8'hf9
`define RMGC_STATUS_ADDR 8'hfb
`define RMGC_ID_ADDR 8'hfd
// arbitrary card identity value
`define RMGC_CARD_ID 16'h00a5
`define RMGC_CFG_OSD_BIT 7
`define RMGC_CFG_RESET 16'h0000
// gain word: [1:0] mux gain, [4:2] converter gain
`define RMGC_GAIN_MUX_LSB 0
`define RMGC_GAIN_MUX_W 2
`define RMGC_GAIN_ADC_LSB 2
`define RMGC_GAIN_ADC_W 3
`define RMGC_GAIN_MASK 16'h001f
`define RMGC_MUX_G0P1 2'h0
`define RMGC_MUX_G1 2'h1
`define RMGC_MUX_G10 2'h2
`define RMGC_MUX_G100 2'h3
`define RMGC_ADC_G1 3'h0
`define RMGC_ADC_G2 3'h1
`define RMGC_ADC_G4 3'h2
`define RMGC_ADC_G8 3'h3
`define RMGC_ADC_AUTO 3'h4
// reset gain: mux x1, converter x1
`define RMGC_GAIN_RESET 16'h0001
`define RMGC_FULL_SCALE 16'h7fff

`endif

// file: rtl/rmgc_gain_bank.v
// per-channel gain register bank
`timescale 1ns/100ps
`default_nettype none
`include "rmgc_defines.vh"

module rmgc_gain_bank (
    input wire clk_sys,
    input wire rst_n,
    input wire wr_en,
    input wire [3:0] wr_ch,
    input wire [15:0] wr_data,
    input wire [3:0] rd_ch,
    output wire [15:0] rd_gain
);
    reg [15:0] gain_mem [0:`RMGC_NUM_CH-1];
    genvar g;
    generate
        for (g = 0; g < `RMGC_NUM_CH; g = g + 1) begin : g_ch
            localparam [3:0] CH_IDX = g;
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    gain_mem[g] <= `RMGC_GAIN_RESET; // [R16]
                end else if (wr_en && wr_ch == CH_IDX) begin
                    gain_mem[g] <= wr_data & `RMGC_GAIN_MASK; // [R12]
                end
            end
        end
    endgenerate
    assign rd_gain = gain_mem[rd_ch];
endmodule
`default_nettype wire

// file: rtl/rmgc_top.v
// relay input mux channel select, gain control and register port
//
// Contract
// [R01] Sixteen input channels, each with its own data register holding its reading.
// [R02] Host selects a channel only by addressing its data register; mux routes it.
// [R03] Bit 7 of config register 249 turns open-sensor detection on or off.
// [R04] Detection on and input open gives positive full scale at gains 1 to 800.
// [R05] Detection gives no open indication when mux gain is below one.
// [R06] Overrange input returns the same positive full scale as an open input.
// [R07] Host tells overrange from open by clearing detection and reading again.
// [R08] One gain register per input channel holds that channel's gain selection.
// [R09] Gain register takes mux gain 0.1, 1, 10 or 100.
// [R10] Gain register takes converter gain 1, 2, 4, 8 or autorange.
// [R11] On a reading request the channel's gain drives both amplifiers; a request while a conversion is pending leaves both gains unchanged.
// [R12] Host may read or overwrite any gain register at any time.
// [R13] Each data read forwards the channel's gain value to the converter card; a data read made while a conversion is pending forwards nothing.
// [R14] Config bit 7 one means detection on, zero means detection off.
// [R15] Card status register always reads zero.
// [R16] Reset clears detection bit and sets every gain register to a default.
`timescale 1ns/100ps
`default_nettype none
`include "rmgc_defines.vh"

module rmgc_top (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [15:0] conv_data,
    input wire conv_valid,
    input wire input_open,
    input wire input_overrange,
    output reg [3:0] mux_sel,
    output reg mux_route,
    output reg [1:0] mux_gain,
    output reg [2:0] conv_gain,
    output reg conv_gain_strobe,
    output reg conv_start,
    output reg osd_enable
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;

    reg [1:0] state;
    reg [15:0] cfg;
    reg [15:0] data_mem [0:`RMGC_NUM_CH-1];
    reg [3:0] cur_ch;
    reg [15:0] next_reading;

    wire hit_data;
    wire hit_gain;
    wire [3:0] addr_ch;
    wire [15:0] sel_gain;
    wire [15:0] rd_gain;
    wire osd_on;
    wire osd_usable;

    assign hit_data = ((reg_addr & 8'hf0) == `RMGC_DATA_BASE); // [R02]
    assign hit_gain = ((reg_addr & 8'hf0) == `RMGC_GAIN_BASE);
    assign addr_ch = reg_addr[3:0];
    assign osd_on = cfg[`RMGC_CFG_OSD_BIT]; // [R14]
    // detection useless at mux gain 0.1; uses the gain latched at start
    assign osd_usable = osd_on &&
        (mux_gain != `RMGC_MUX_G0P1); // [R05]

    rmgc_gain_bank u_gain (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(reg_wr && hit_gain), // [R08]
        .wr_ch(addr_ch),
        .wr_data(reg_wdata),
        .rd_ch(addr_ch),
        .rd_gain(rd_gain)
    );
    assign sel_gain = rd_gain;

    always @* begin
        if (input_overrange || (osd_usable && input_open)) begin
            next_reading = `RMGC_FULL_SCALE; // [R04] [R06]
        end else begin
            next_reading = conv_data;
        end
    end

    // config register
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= `RMGC_CFG_RESET; // [R16]
        end else if (reg_wr && reg_addr == `RMGC_CFG_ADDR) begin
            cfg <= reg_wdata; // [R03]
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osd_enable <= 1'b0;
        end else begin
            osd_enable <= osd_on; // [R03]
        end
    end

    // read-data mux, answer one cycle after strobe
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (hit_data) begin
                reg_rdata <= data_mem[addr_ch]; // [R01]
            end else if (hit_gain) begin
                reg_rdata <= rd_gain; // [R12]
            end else if (reg_addr == `RMGC_CFG_ADDR) begin
                reg_rdata <= cfg;
            end else if (reg_addr == `RMGC_STATUS_ADDR) begin
                reg_rdata <= 16'h0000; // [R15]
            end else if (reg_addr == `RMGC_ID_ADDR) begin
                reg_rdata <= `RMGC_CARD_ID;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // conversion sequencer
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cur_ch <= 4'h0;
            mux_sel <= 4'h0;
            mux_route <= 1'b0;
            mux_gain <= `RMGC_MUX_G1;
            conv_gain <= `RMGC_ADC_G1;
            conv_gain_strobe <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_gain_strobe <= 1'b0;
            conv_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (reg_rd && hit_data) begin
                        cur_ch <= addr_ch;
                        mux_sel <= addr_ch; // [R02]
                        mux_route <= 1'b1;
                        mux_gain <= sel_gain[1:0]; // [R09] [R11]
                        conv_gain <= sel_gain[4:2]; // [R10] [R11]
                        conv_gain_strobe <= 1'b1; // [R13]
                        conv_start <= 1'b1;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (conv_valid) begin
                        mux_route <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // data registers updated by completed conversions
    genvar g;
    generate
        for (g = 0; g < `RMGC_NUM_CH; g = g + 1) begin : g_data
            localparam [3:0] CH_IDX = g;
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    data_mem[g] <= 16'h0000;
                end else if (state == ST_WAIT && conv_valid &&
                             cur_ch == CH_IDX) begin
                    data_mem[g] <= next_reading; // [R01]
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: bench/rmgc_chk_sva.sv
// assertions on the relay mux gain control ports
`timescale 1ns/100ps
`default_nettype none
module rmgc_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic conv_valid,
    input wire logic [3:0] mux_sel,
    input wire logic mux_route,
    input wire logic [2:0] conv_gain,
    input wire logic conv_gain_strobe,
    input wire logic conv_start,
    input wire logic osd_enable
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
a_start_pair: assert property (conv_start |-> conv_gain_strobe)
    else $error("start without gain");
a_read_start: assert property (reg_rd && reg_addr < 8'h10 && !mux_route
    |=> conv_start && mux_sel == $past(reg_addr[3:0]))
    else $error("read did not start");
a_route_held: assert property (conv_start |-> mux_route)
    else $error("route open at start");
a_route_end: assert property (mux_route && conv_valid |=> !mux_route)
    else $error("route kept");
a_osd_follow: assert property (reg_wr && reg_addr == 8'hf9
    |=> ##1 osd_enable == $past(reg_wdata[7], 2))
    else $error("detect enable wrong");
a_status_zero: assert property (reg_rd && reg_addr == 8'hfb
    |=> reg_rdata == 16'h0)
    else $error("status not zero");
a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not idle");
a_gain_code: assert property (conv_gain_strobe |-> conv_gain <= 3'h4)
    else $error("bad converter gain");
cover property (conv_start);
cover property (conv_valid && mux_route);
cover property (osd_enable && conv_start);
endmodule
bind rmgc_top rmgc_chk u_chk (.*);
`default_nettype wire

// file: bench/rmgc_conv_model.sv
// converter card model answering gain forwards
`timescale 1ns/100ps
`default_nettype none
module rmgc_conv_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic conv_gain_strobe,
    input wire logic [2:0] conv_gain,
    output logic conv_valid,
    output logic [15:0] conv_data
);
logic [2:0] g;
logic [3:0] cnt;
logic slow;
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        conv_valid <= 1'b0;
        conv_data <= 16'h0;
        cnt <= 4'h0;
        slow <= 1'b0;
        g <= 3'h0;
    end else begin
        conv_valid <= 1'b0;
        // data line toggles while not valid
        conv_data <= ~conv_data;
        if (conv_gain_strobe) begin
            g <= conv_gain;
            cnt <= slow ? 4'h9 : 4'h2;
            slow <= !slow;
        end else if (cnt == 4'h1) begin
            conv_valid <= 1'b1;
            conv_data <= 16'h0123 ^ {13'h0, g};
            cnt <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
end
endmodule
`default_nettype wire

// file: bench/relay_mux_channel_gain_control_tb.sv
// register level test of the relay mux gain control
`timescale 1ns/100ps
`default_nettype none
module relay_mux_channel_gain_control_tb;
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic [7:0] reg_addr = 8'h0;
logic [15:0] reg_wdata = 16'h0;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic input_open = 1'b0;
logic input_overrange = 1'b0;
logic [15:0] reg_rdata, conv_data;
logic [3:0] mux_sel;
logic [1:0] mux_gain;
logic [2:0] conv_gain;
logic mux_route, conv_gain_strobe, conv_start, osd_enable, conv_valid;
logic osd = 1'b0;
logic [15:0] last [16] = '{default: 16'h0};
int failures = 0;
int checks_done = 0;
int cyc = 0;
rmgc_top dut (.*);
rmgc_conv_model u_cv (.*);
initial begin
    forever #12.5 clk_sys = ~clk_sys;
end
function automatic logic [4:0] gv(input int c);
    return {3'(c % 5), 2'(c % 4)};
endfunction
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
        failures++;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
endtask
task automatic conv(input logic [3:0] c, input logic op, input logic ov);
    logic [4:0] g;
    int n;
    g = gv(c);
    @(posedge clk_sys);
    input_open <= op;
    input_overrange <= ov;
    rd({4'h0, c}, last[c]);
    chk({conv_start, conv_gain_strobe, mux_route, 4'h0, mux_sel, mux_gain,
        conv_gain}, {3'h7, 4'h0, c, g[1:0], g[4:2]});
    n = 0;
    while (mux_route !== 1'b0 && n < 40) begin
        @(posedge clk_sys);
        #1 n++;
    end
    chk(16'(mux_route), 16'h0);
    last[c] = ov || (op && osd && g[1:0] != 2'h0) ? 16'h7fff
        : 16'h0123 ^ {13'h0, g[4:2]};
endtask
task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
        $display("STATUS OK");
    end else begin
        $display("STATUS NOT OK");
    end
    $finish;
endtask
always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
        failures++;
        summarize();
    end
end
initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({13'h0, osd_enable, mux_gain}, 16'h1);
    rd(8'hf9, 16'h0);
    for (int i = 0; i < 16; i++) rd(8'(8'hc0 + i), 16'h1);
    wr(8'hfb, 16'hffff);
    rd(8'hfb, 16'h0);
    rd(8'h80, 16'h0);
    $display("reset test end");
    for (int i = 0; i < 16; i++) wr(8'(8'hc0 + i), 16'hffe0 | gv(i));
    for (int i = 0; i < 16; i++) rd(8'(8'hc0 + i), 16'(gv(i)));
    $display("gain test end");
    for (int r = 0; r < 3; r++) begin
        osd = r == 1;
        wr(8'hf9, {8'h0, osd, 7'h0});
        @(posedge clk_sys);
        #1 chk(16'(osd_enable), 16'(osd));
        rd(8'hf9, {8'h0, osd, 7'h0});
        for (int c = 1; c < 6; c++) conv(4'(c), r < 2 && c != 2, c == 2);
    end
    $display("reading test end");
    summarize();
end
endmodule
`default_nettype wire
